/* logic/ufc_tx.sv */
// Serial transmitter with frame format, enable control and baud generator
`timescale 1ns/1ns
// How it works
// - NRZ frame: start, 8 or 9 data, optional parity, 1-2 stops; reset 8N1.
// - Even, odd or no parity via separate enable and type bits.
// - Transmit and receive share one format and one 8-bit baud generator.
// - Data bits leave the line least significant first.
// - Line sits high whenever no frame is sent.
// - Pins belong to the serial function only with mode and all enables set.
// - Disable empties buffer, clears transmit/receive enables, break bit and error flags, sets idle/empty.
// - Global disable aborts traffic at once; format and baud settings persist.
// - Stop count setting affects the transmitter only.
// - With address detect, data MSB marks an address character.
// - Ninth data bit comes from the transmit bit eight field.
// - Shift register reloads only after the previous stop bit.
// - Sending needs enable, data and baud ticks; early data waits for enable.
// - Clearing transmit enable mid-frame aborts and resets the transmitter.
// - Data writes are ignored while the empty flag is zero.
// - Empty and idle flags clear only by status access then data write.
// - Empty flag set when data can be accepted; gated onto interrupt.
// - Write during frame is held; write when idle starts frame, empty stays.
// - Idle flag sets when a data frame or break frame completes.
// - Break: start bit, multiples of thirteen zeros, then stop bits.
// - A break never raises a transmit interrupt.
// - Breaks repeat while break bit set; then finish and send stops.
// - Baud equals clock over 64(N+1) low speed or 16(N+1) high speed.
// - Idle interrupt enable routes idle flag onto the shared request.
module ufc_tx (
  input wire logic mclk,
  input wire logic reset,
  input wire ufc_pkg::ufc_bus_s bus,
  output logic [7:0] rdata,
  output logic tx_out,
  output logic tx_oe,
  output logic rx_pin_en,
  output logic irq
);
  import ufc_pkg::*;

  logic glb_en_q;
  logic mode_q;
  logic txen_q;
  logic rxen_q;
  logic nine_q;
  logic par_en_q;
  logic par_odd_q;
  logic stop2_q;
  logic bit8_q;
  logic hs_q;
  logic addr_det_q;
  logic brk_q;
  logic the_q;
  logic teie_q;
  logic [7:0] baud_n_q;
  logic [7:0] data_q;
  logic empty_q;
  logic idle_q;
  logic stat_seen_q;
  logic hold_full_q;
  logic tsr_full_q;
  logic [8:0] tsr_q;
  logic par_q;
  logic [5:0] pre_q;
  logic [7:0] div_q;
  logic tick_q;
  ufc_state_e state_q;
  logic [3:0] cnt_q;
  logic is_brk_q;
  logic idle_brk_q;
  logic frame_end;
  logic wr_ctl1;
  logic wr_ctl2;
  logic wr_data;
  logic dis;
  logic abort;
  logic tx_run;
  logic data_wr;
  logic tsr_free;
  logic tsr_load;
  logic [7:0] load_byte;
  logic [8:0] load_word;
  logic [3:0] nbits;
  logic start_next;

  assign wr_ctl1 = bus.wr && (bus.addr == ADDR_CTL1);
  assign wr_ctl2 = bus.wr && (bus.addr == ADDR_CTL2);
  assign wr_data = bus.wr && (bus.addr == ADDR_DATA);
  assign dis = wr_ctl1 && !bus.wdata[C1_GLB_EN] && glb_en_q;
  assign abort = dis || (txen_q && wr_ctl2 && !bus.wdata[C2_TXEN]);
  assign tx_run = glb_en_q && mode_q && txen_q;
  assign data_wr = wr_data && empty_q && stat_seen_q;
  assign nbits = nine_q ? BITS_NINE : BITS_EIGHT;
  assign start_next = brk_q || tsr_full_q;

  // Frame ends on the tick that closes the last stop bit
  always_comb begin
    frame_end = 1'b0;
    if (tick_q && (state_q == S_STOP) && !(stop2_q && (cnt_q == 4'h0))) begin
      frame_end = 1'b1;
    end
  end

  // reload only when the shift register frees up
  assign tsr_free = !tsr_full_q || (frame_end && !is_brk_q);
  assign tsr_load = tsr_free && (hold_full_q || data_wr);
  assign load_byte = hold_full_q ? data_q : bus.wdata;
  // ninth bit from the control field
  assign load_word = {nine_q && bit8_q, load_byte};

  // Control one: format bits survive a disable
  always_ff @(posedge mclk) begin
    if (reset) begin
      glb_en_q <= 1'b0;
      nine_q <= RST_NINE;
      par_en_q <= RST_PAR_EN;
      par_odd_q <= 1'b0;
      stop2_q <= RST_STOP2;
      bit8_q <= 1'b0;
    end else if (wr_ctl1) begin
      glb_en_q <= bus.wdata[C1_GLB_EN];
      nine_q <= bus.wdata[C1_NINE];
      par_en_q <= bus.wdata[C1_PAR_EN];
      par_odd_q <= bus.wdata[C1_PAR_ODD];
      // stop count used by the transmitter only
      stop2_q <= bus.wdata[C1_STOP2];
      bit8_q <= bus.wdata[C1_BIT8];
    end
  end

  // Control two
  always_ff @(posedge mclk) begin
    if (reset) begin
      txen_q <= 1'b0;
      rxen_q <= 1'b0;
      hs_q <= 1'b0;
      addr_det_q <= 1'b0;
      brk_q <= 1'b0;
      the_q <= 1'b0;
      teie_q <= 1'b0;
    end else if (dis) begin
      txen_q <= 1'b0;
      rxen_q <= 1'b0;
      brk_q <= 1'b0;
    end else if (wr_ctl2) begin
      txen_q <= bus.wdata[C2_TXEN];
      rxen_q <= bus.wdata[C2_RXEN];
      hs_q <= bus.wdata[C2_HS];
      // address marking is the data MSB, sent as written
      addr_det_q <= bus.wdata[C2_ADDR_DET];
      brk_q <= bus.wdata[C2_BRK];
      the_q <= bus.wdata[C2_THE];
      teie_q <= bus.wdata[C2_TEIE];
    end
  end

  // Baud divider and mode select
  always_ff @(posedge mclk) begin
    if (reset) begin
      baud_n_q <= RST_BAUD;
      mode_q <= 1'b0;
    end else begin
      if (bus.wr && (bus.addr == ADDR_BAUD)) begin
        baud_n_q <= bus.wdata;
      end
      if (bus.wr && (bus.addr == ADDR_SIC0)) begin
        mode_q <= bus.wdata[SIC_MODE];
      end
    end
  end

  // prescale by 64 or 16, then by N+1
  always_ff @(posedge mclk) begin
    if (reset || !tx_run) begin
      pre_q <= 6'h00;
      div_q <= 8'h00;
      tick_q <= 1'b0;
    end else begin
      tick_q <= 1'b0;
      if (pre_q == (hs_q ? PRE_HIGH : PRE_LOW)) begin
        pre_q <= 6'h00;
        if (div_q == baud_n_q) begin
          div_q <= 8'h00;
          tick_q <= 1'b1;
        end else begin
          div_q <= div_q + 8'h01;
        end
      end else begin
        pre_q <= pre_q + 6'h01;
      end
    end
  end

  // Status access arms the next data write
  always_ff @(posedge mclk) begin
    if (reset) begin
      stat_seen_q <= 1'b0;
    end else if (bus.rd && (bus.addr == ADDR_STATUS)) begin
      stat_seen_q <= 1'b1;
    end else if (wr_data) begin
      stat_seen_q <= 1'b0;
    end
  end

  // Holding buffer and shift register
  always_ff @(posedge mclk) begin
    if (reset || abort) begin
      hold_full_q <= 1'b0;
      tsr_full_q <= 1'b0;
      data_q <= 8'h00;
      tsr_q <= 9'h000;
      par_q <= 1'b0;
    end else begin
      if (frame_end && !is_brk_q) begin
        tsr_full_q <= 1'b0;
      end
      // straight load when free, else held
      if (tsr_load) begin
        tsr_q <= load_word;
        par_q <= (^load_word) ^ par_odd_q;
        tsr_full_q <= 1'b1;
        hold_full_q <= 1'b0;
      end else if (data_wr) begin
        data_q <= bus.wdata;
        hold_full_q <= 1'b1;
      end
    end
  end

  // empty flag tracks room in the data register
  always_ff @(posedge mclk) begin
    if (reset || abort) begin
      empty_q <= 1'b1;
    end else if (tsr_load) begin
      empty_q <= 1'b1;
    end else if (data_wr) begin
      // cleared by the armed write only
      empty_q <= 1'b0;
    end
  end

  // idle flag, set wins over the clearing write
  always_ff @(posedge mclk) begin
    if (reset || abort) begin
      idle_q <= 1'b1;
      idle_brk_q <= 1'b0;
    end else if (frame_end) begin
      idle_q <= 1'b1;
      idle_brk_q <= is_brk_q;
    end else if (data_wr) begin
      idle_q <= 1'b0;
      idle_brk_q <= 1'b0;
    end
  end

  // Frame sequencer, one step per baud tick
  always_ff @(posedge mclk) begin
    if (reset || abort) begin
      state_q <= S_IDLE;
      cnt_q <= 4'h0;
      is_brk_q <= 1'b0;
      tx_out <= 1'b1;
    end else if (tick_q) begin
      case (state_q)
        S_IDLE: begin
          // waits for enable, data and a tick
          if (start_next) begin
            state_q <= S_START;
            is_brk_q <= brk_q;
            tx_out <= 1'b0;
          end
        end
        S_START: begin
          if (is_brk_q) begin
            state_q <= S_BRK;
            cnt_q <= 4'h1;
            tx_out <= 1'b0;
          end else begin
            state_q <= S_DATA;
            cnt_q <= 4'h1;
            tx_out <= tsr_q[0];
          end
        end
        S_DATA: begin
          if (cnt_q == nbits) begin
            cnt_q <= 4'h0;
            if (par_en_q) begin
              state_q <= S_PAR;
              tx_out <= par_q;
            end else begin
              state_q <= S_STOP;
              tx_out <= 1'b1;
            end
          end else begin
            tx_out <= tsr_q[cnt_q];
            cnt_q <= cnt_q + 4'h1;
          end
        end
        S_PAR: begin
          state_q <= S_STOP;
          tx_out <= 1'b1;
        end
        S_STOP: begin
          if (stop2_q && (cnt_q == 4'h0)) begin
            cnt_q <= 4'h1;
          end else if (brk_q || tsr_load || (tsr_full_q && is_brk_q)) begin
            // Back to back frames skip the extra idle bit
            state_q <= S_START;
            is_brk_q <= brk_q;
            cnt_q <= 4'h0;
            tx_out <= 1'b0;
          end else begin
            state_q <= S_IDLE;
            cnt_q <= 4'h0;
          end
        end
        S_BRK: begin
          if (cnt_q == BRK_LEN) begin
            // repeat while set, else finish with stops
            if (brk_q) begin
              cnt_q <= 4'h1;
            end else begin
              state_q <= S_STOP;
              cnt_q <= 4'h0;
              tx_out <= 1'b1;
            end
          end else begin
            cnt_q <= cnt_q + 4'h1;
          end
        end
        default: begin
          state_q <= S_IDLE;
          tx_out <= 1'b1;
        end
      endcase
    end
  end

  // pins handed over only with mode and all enables
  always_ff @(posedge mclk) begin
    if (reset) begin
      tx_oe <= 1'b0;
      rx_pin_en <= 1'b0;
    end else begin
      tx_oe <= glb_en_q && mode_q && txen_q && rxen_q;
      rx_pin_en <= glb_en_q && mode_q && txen_q && rxen_q;
    end
  end

  // an idle caused by a break stays off the request
  always_ff @(posedge mclk) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= glb_en_q && ((empty_q && teie_q) || (idle_q && the_q && !idle_brk_q));
    end
  end

  // Read port; receive path is absent, so its flags sit at their disabled values
  always_ff @(posedge mclk) begin
    if (reset) begin
      rdata <= 8'h00;
    end else if (bus.rd) begin
      rdata <= 8'h00;
      case (bus.addr)
        ADDR_STATUS: begin
          rdata[ST_RX_IDLE] <= 1'b1;
          rdata[ST_TX_IDLE] <= idle_q;
          rdata[ST_TX_EMPTY] <= empty_q;
        end
        ADDR_CTL1: begin
          rdata[C1_GLB_EN] <= glb_en_q;
          rdata[C1_NINE] <= nine_q;
          rdata[C1_PAR_EN] <= par_en_q;
          rdata[C1_PAR_ODD] <= par_odd_q;
          rdata[C1_STOP2] <= stop2_q;
          rdata[C1_BIT8] <= bit8_q;
        end
        ADDR_CTL2: begin
          rdata[C2_TXEN] <= txen_q;
          rdata[C2_RXEN] <= rxen_q;
          rdata[C2_HS] <= hs_q;
          rdata[C2_ADDR_DET] <= addr_det_q;
          rdata[C2_BRK] <= brk_q;
          rdata[C2_THE] <= the_q;
          rdata[C2_TEIE] <= teie_q;
        end
        ADDR_BAUD: begin
          rdata <= baud_n_q;
        end
        ADDR_SIC0: begin
          rdata[SIC_MODE] <= mode_q;
        end
        default: begin
          rdata <= 8'h00;
        end
      endcase
    end
  end
endmodule

/* logic/ufc_pkg.sv */
// Package for the serial transmitter: register map, fields, states and bus carrier
package ufc_pkg;
  // Register addresses on the plain register port
  localparam logic [2:0] ADDR_STATUS = 3'h0;
  localparam logic [2:0] ADDR_CTL1 = 3'h1;
  localparam logic [2:0] ADDR_CTL2 = 3'h2;
  localparam logic [2:0] ADDR_DATA = 3'h3;
  localparam logic [2:0] ADDR_BAUD = 3'h4;
  localparam logic [2:0] ADDR_SIC0 = 3'h5;

  // Status fields
  localparam int ST_RX_IDLE = 0;
  localparam int ST_TX_IDLE = 1;
  localparam int ST_TX_EMPTY = 2;
  localparam int ST_RX_AVAIL = 3;
  localparam int ST_NOISE = 4;
  localparam int ST_FRAMING = 5;
  localparam int ST_OVERRUN = 6;
  localparam int ST_PARITY = 7;

  // Control one fields
  localparam int C1_GLB_EN = 7;
  localparam int C1_NINE = 6;
  localparam int C1_PAR_EN = 5;
  localparam int C1_PAR_ODD = 4;
  localparam int C1_STOP2 = 3;
  localparam int C1_BIT8 = 0;

  // Control two fields
  localparam int C2_TXEN = 7;
  localparam int C2_RXEN = 6;
  localparam int C2_HS = 5;
  localparam int C2_ADDR_DET = 4;
  localparam int C2_BRK = 3;
  localparam int C2_THE = 1;
  localparam int C2_TEIE = 0;

  // Interface control zero field
  localparam int SIC_MODE = 0;

  // Reset values of the format fields: 8 data bits, no parity, 1 stop bit
  localparam logic RST_NINE = 1'b0;
  localparam logic RST_PAR_EN = 1'b0;
  localparam logic RST_STOP2 = 1'b0;
  localparam logic [7:0] RST_BAUD = 8'h00;

  // Prescale terminal counts: divide by 64 (low speed) or 16 (high speed)
  localparam logic [5:0] PRE_LOW = 6'h3f;
  localparam logic [5:0] PRE_HIGH = 6'h0f;
  // Zero bits per break character after its start bit
  localparam logic [3:0] BRK_LEN = 4'hd;
  localparam logic [3:0] BITS_EIGHT = 4'h8;
  localparam logic [3:0] BITS_NINE = 4'h9;

  typedef enum logic [5:0] {
    S_IDLE = 6'b000001,
    S_START = 6'b000010,
    S_DATA = 6'b000100,
    S_PAR = 6'b001000,
    S_STOP = 6'b010000,
    S_BRK = 6'b100000
  } ufc_state_e;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [2:0] addr;
    logic [7:0] wdata;
  } ufc_bus_s;
endpackage

/* verif/ufc_tx_properties.sv */
// Port-level assertions for the serial transmitter
`timescale 1ns/1ns
module ufc_tx_properties (
  input wire logic mclk,
  input wire logic reset,
  input wire ufc_pkg::ufc_bus_s bus,
  input wire logic [7:0] rdata,
  input wire logic tx_out,
  input wire logic tx_oe,
  input wire logic rx_pin_en,
  input wire logic irq
);
  import ufc_pkg::*;
  logic [7:0] run_q;
  logic last_q;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  always_ff @(posedge mclk) begin
    last_q <= tx_out;
    if (reset || tx_out != last_q) begin
      run_q <= 8'h00;
    end else if (run_q != 8'hff) begin
      run_q <= run_q + 8'h01;
    end
  end

  reset_line_a: assert property (disable iff (1'b0) reset |=> tx_out && !tx_oe && !rx_pin_en)
    else $error("line or pin enables wrong after reset");
  quiet_start_a: assert property ($fell(reset) |-> tx_out [*8])
    else $error("line left idle without enables");
  pin_pair_a: assert property (tx_oe == rx_pin_en)
    else $error("pin enables disagree");
  bit_width_a: assert property ($fell(tx_out) |-> run_q >= 8'd15)
    else $error("bit shorter than one baud period");
  status_map_a: assert property (bus.rd && bus.addr == ADDR_STATUS |=>
    rdata[ST_RX_IDLE] && rdata[7:3] == 5'h00)
    else $error("status read shows receive flags");
  glb_off_a: assert property (bus.wr && bus.addr == ADDR_CTL1 && !bus.wdata[C1_GLB_EN] |->
    ##2 (tx_out && !tx_oe && !irq))
    else $error("global disable did not release the line");
  txen_off_a: assert property (bus.wr && bus.addr == ADDR_CTL2 && !bus.wdata[C2_TXEN] |->
    ##2 tx_out [*4])
    else $error("transmit disable did not stop the frame");
  irq_gate_a: assert property (bus.wr && bus.addr == ADDR_CTL2 && bus.wdata[1:0] == 2'b00 |->
    ##2 !irq)
    else $error("request raised with both enables clear");

  cover property ($fell(tx_out));
  cover property ($rose(irq));
  cover property ($fell(tx_oe));
endmodule

/* verif/ufc_line_monitor.sv */
// Remote serial receiver model sampling the transmit line mid-bit
`timescale 1ns/1ns
module ufc_line_monitor (
  input wire logic mclk,
  input wire logic line,
  input wire logic [3:0] nbits,
  input wire logic [7:0] period,
  output logic [12:0] frame,
  output int count
);
  initial begin
    frame = 13'h0000;
    count = 0;
    forever begin
      @(negedge line);
      frame = 13'h0000;
      repeat (period / 2) @(posedge mclk);
      for (int i = 0; i < nbits; i++) begin
        frame[i] = line;
        if (i < nbits - 1) repeat (period) @(posedge mclk);
      end
      count++;
    end
  end
endmodule

/* verif/ufc_tx_tb.sv */
// Testbench for the serial transmitter: register traffic and line frames
`timescale 1ns/1ns
module ufc_tx_tb;
  import ufc_pkg::*;
  logic mclk;
  logic reset;
  ufc_bus_s bus;
  logic [7:0] rdata;
  logic tx_out;
  logic tx_oe;
  logic rx_pin_en;
  logic irq;
  logic [3:0] nbits;
  logic [7:0] period;
  logic [12:0] frame;
  int count;
  int fails = 0;
  int checks = 0;
  int cycles = 0;
  int low;
  int c0;

  ufc_tx DUT (.mclk(mclk), .reset(reset), .bus(bus), .rdata(rdata), .tx_out(tx_out),
    .tx_oe(tx_oe), .rx_pin_en(rx_pin_en), .irq(irq));
  ufc_line_monitor u_mon (.mclk(mclk), .line(tx_out), .nbits(nbits), .period(period),
    .frame(frame), .count(count));

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Hangs are cut short well beyond the longest sequence
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      $display("Error timeout expected completion seen hang");
      end_of_test();
    end
  end

  task automatic chk(input string name, input logic [12:0] exp, input logic [12:0] got);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge mclk);
    bus.wr <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge mclk);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge mclk);
    bus.rd <= 1'b0;
    #1;
    chk($sformatf("register %0d", a), {5'h00, exp}, {5'h00, rdata});
  endtask

  task automatic send(input logic [7:0] d, input logic [7:0] st);
    rd(ADDR_STATUS, st);
    wr(ADDR_DATA, d);
  endtask

  task automatic frame_chk(input logic [12:0] exp);
    int c;
    int n;
    c = count;
    n = 0;
    while (count == c && n < 2000) begin
      @(posedge mclk);
      n++;
    end
    #1;
    chk("frame", exp, frame & ((13'h0001 << nbits) - 13'h0001));
    // The count moves at the last stop bit's middle; let that bit finish before going on
    repeat (period) @(posedge mclk);
  endtask

  initial begin
    reset = 1'b1;
    bus = '0;
    nbits = 4'ha;
    period = 8'h10;
    repeat (10) @(posedge mclk);
    reset <= 1'b0;
    rd(ADDR_STATUS, 8'h07);
    rd(3'h7, 8'h00);
    rd(ADDR_CTL1, 8'h00);
    wr(ADDR_BAUD, 8'h00);
    wr(ADDR_SIC0, 8'h01);
    wr(ADDR_CTL1, 8'h80);
    send(8'h5a, 8'h07);
    wr(ADDR_CTL2, 8'he1);
    frame_chk({4'h1, 8'h5a, 1'b0});
    chk("tx_oe", 13'h0001, {12'h000, tx_oe});
    chk("irq", 13'h0001, {12'h000, irq});
    send(8'ha5, 8'h07);
    rd(ADDR_STATUS, 8'h05);
    wr(ADDR_DATA, 8'h3c);
    rd(ADDR_STATUS, 8'h01);
    wr(ADDR_DATA, 8'hff);
    frame_chk({4'h1, 8'ha5, 1'b0});
    frame_chk({4'h1, 8'h3c, 1'b0});
    c0 = count;
    repeat (400) @(posedge mclk);
    chk("frame count", c0[12:0], count[12:0]);
    rd(ADDR_STATUS, 8'h07);
    wr(ADDR_CTL2, 8'he0);
    repeat (3) @(posedge mclk);
    chk("irq", 13'h0000, {12'h000, irq});
    wr(ADDR_CTL2, 8'he2);
    repeat (3) @(posedge mclk);
    chk("irq", 13'h0001, {12'h000, irq});
    // Slower rate, nine bits with odd parity and two stops
    wr(ADDR_BAUD, 8'h01);
    wr(ADDR_CTL1, 8'hf9);
    nbits = 4'hd;
    period = 8'h20;
    send(8'h3c, 8'h07);
    frame_chk({2'b11, ~^{1'b1, 8'h3c}, 1'b1, 8'h3c, 1'b0});
    wr(ADDR_CTL1, 8'ha0);
    nbits = 4'hb;
    send(8'h07, 8'h07);
    frame_chk({1'b1, ^8'h07, 8'h07, 1'b0});
    wr(ADDR_CTL2, 8'he8);
    low = 0;
    while (tx_out !== 1'b0 && low < 200) begin
      @(posedge mclk);
      #1;
      low++;
    end
    // Break bit is cleared inside the first break, so exactly one follows
    low = 1;
    while (low < 1000) begin
      if (low == 100) begin
        wr(ADDR_CTL2, 8'he0);
        #1;
        low += 2;
      end else begin
        @(posedge mclk);
        #1;
        if (tx_out !== 1'b0) break;
        low++;
      end
    end
    chk("break length", 13'd448, low[12:0]);
    nbits = 4'ha;
    send(8'h00, 8'h07);
    repeat (100) @(posedge mclk);
    wr(ADDR_CTL2, 8'h60);
    @(posedge mclk);
    #1;
    chk("tx_out", 13'h0001, {12'h000, tx_out});
    rd(ADDR_STATUS, 8'h07);
    wr(ADDR_CTL2, 8'hf8);
    wr(ADDR_CTL1, 8'h00);
    repeat (3) @(posedge mclk);
    rd(ADDR_CTL2, 8'h30);
    rd(ADDR_BAUD, 8'h01);
    rd(ADDR_STATUS, 8'h07);
    chk("tx_oe", 13'h0000, {12'h000, tx_oe});
    chk("irq", 13'h0000, {12'h000, irq});
    end_of_test();
  end
endmodule

bind ufc_tx ufc_tx_properties u_props (.mclk(mclk), .reset(reset), .bus(bus), .rdata(rdata),
  .tx_out(tx_out), .tx_oe(tx_oe), .rx_pin_en(rx_pin_en), .irq(irq));
